// File: lcm_consts.svh
// lcm_consts.svh: offsets, field positions, reset values and command codes
// assumes inclusion by lcm_mixer.sv and its bench; lcm_pkg.sv does not include it
//
// Functional notes
// - block three line count is the smaller of block one and block two sizes
// - block four size comes from the lines-per-frame field
// - dual panel blanks lines between each block size and half frame
// - cursor width field holds pixels from character origin minus one
// - style bit 7 clear gives underscore cursor, set gives block cursor
// - height field places underscore line or sets block cursor height
// - step direction 00 right, 01 left, 10 up, 11 down; commands 4C-4F
// - after each memory access step one unit sideways or one pitch vertically
// - the cursor step is also the memory address increment
// - cursor moves in address units even with nine-pixel characters
// - cursor form command carries width then style/height as parameters
// - layer count bit 4 selects two or three layers
// - bit 3 selects text or graphics for screen block three
// - bit 2 selects text or graphics for screen block one
// - screen blocks two and four are graphics only
// - mix field 00 OR, 01 XOR, 10 AND, each then ORed with third layer
// - one composition method per layer, shared by its screen blocks
// - text first layer disables third layer; layers two and three graphics
// - each block size value equals line count minus one
`ifndef LCM_CONSTS_SVH
`define LCM_CONSTS_SVH

// ==========================================================================
// register addresses
`define LCM_ADDR_CURSOR_WIDTH   16'h8015
`define LCM_ADDR_CURSOR_STYLE   16'h8016
`define LCM_ADDR_CURSOR_STEP    16'h8017
`define LCM_ADDR_LAYER_MIX      16'h8018

// ==========================================================================
// reset values
`define LCM_RST_CURSOR_WIDTH    8'h00
`define LCM_RST_CURSOR_STYLE    8'h00
`define LCM_RST_CURSOR_STEP     8'h00
`define LCM_RST_LAYER_MIX       8'h00

// ==========================================================================
// field positions and masks
`define LCM_WIDTH_MASK          8'h0F
`define LCM_STYLE_MASK          8'h8F
`define LCM_STEP_MASK           8'h03
`define LCM_MIX_MASK            8'h1F
`define LCM_STYLE_BIT           7
`define LCM_COUNT_BIT           4
`define LCM_B3TYPE_BIT          3
`define LCM_B1TYPE_BIT          2

// ==========================================================================
// indirect command codes; form and overlay codes are arbitrary choices
`define LCM_CMD_FORM            8'h60
`define LCM_CMD_OVERLAY         8'h61
`define LCM_CMD_STEP_RIGHT      8'h4C
`define LCM_CMD_STEP_DOWN       8'h4F

`endif

// File: lcm_pkg.sv
// lcm_pkg.sv: types shared by the cursor and layer mixer
// needs no include path; uses nothing from lcm_consts.svh
package lcm_pkg;

  // ========================================================================
  // encodings
  typedef enum logic [1:0] {
    LCM_DIR_RIGHT = 2'b00,
    LCM_DIR_LEFT  = 2'b01,
    LCM_DIR_UP    = 2'b10,
    LCM_DIR_DOWN  = 2'b11
  } lcm_dir_e;

  typedef enum logic [1:0] {
    LCM_MIX_OR  = 2'b00,
    LCM_MIX_XOR = 2'b01,
    LCM_MIX_AND = 2'b10,
    LCM_MIX_RSV = 2'b11
  } lcm_mix_e;

  // parameter collection after an indirect command, gray along the path except the FORM1 to IDLE step
  typedef enum logic [1:0] {
    LCM_PS_IDLE  = 2'b00,
    LCM_PS_FORM0 = 2'b01,
    LCM_PS_FORM1 = 2'b11,
    LCM_PS_OVL0  = 2'b10
  } lcm_pstate_e;

  // ========================================================================
  // frame-stable display settings
  typedef struct packed {
    logic [3:0] width;
    logic [3:0] height;
    logic       block_style;
    logic       three_layer;
    logic       b3_graphics;
    logic       b1_graphics;
    lcm_mix_e   mix;
  } lcm_disp_s;

  // per-pixel layer samples
  typedef struct packed {
    logic l1;
    logic l2;
    logic l3;
  } lcm_layers_s;

endpackage

// File: lcm_mixer.sv
// lcm_mixer.sv: cursor form, cursor stepping and layer composition
// assumes host strobes and display-timing inputs are already on core_clk_in
`timescale 1ns/1ps
`include "lcm_consts.svh"
`default_nettype none

module lcm_mixer (
  input  wire logic                core_clk_in,
  input  wire logic                rst_n_in,
  // direct register access
  input  wire logic                reg_wr_in,
  input  wire logic                reg_rd_in,
  input  wire logic [15:0]         reg_addr_in,
  input  wire logic [7:0]          reg_wdata_in,
  output logic      [7:0]          reg_rdata_out,
  // indirect command access
  input  wire logic                cmd_wr_in,
  input  wire logic                prm_wr_in,
  input  wire logic [7:0]          cmd_data_in,
  // settings held by neighbouring registers
  input  wire logic [7:0]          block_one_lines_in,
  input  wire logic [7:0]          block_two_lines_in,
  input  wire logic [7:0]          frame_lines_in,
  input  wire logic [15:0]         addr_pitch_in,
  input  wire logic                dual_panel_in,
  // cursor address
  input  wire logic                cursor_load_in,
  input  wire logic [15:0]         cursor_load_val_in,
  input  wire logic                mem_access_in,
  output logic      [15:0]         cursor_addr_out,
  // display refresh
  input  wire logic                frame_start_in,
  input  wire logic [7:0]          panel_line_in,
  input  wire logic                lower_panel_in,
  input  wire logic                in_block_three_in,
  input  wire logic                cursor_cell_in,
  input  wire logic [3:0]          cell_x_in,
  input  wire logic [3:0]          cell_y_in,
  input  wire lcm_pkg::lcm_layers_s layers_in,
  output logic      [7:0]          block_three_lines_out,
  output logic      [7:0]          block_four_lines_out,
  output logic                     blank_out,
  output logic                     cursor_on_out,
  output logic                     pixel_out
);

  // ========================================================================
  // registers
  logic [7:0]              cursor_width_cfg_reg;
  logic [7:0]              cursor_style_height_cfg_reg;
  logic [7:0]              cursor_step_direction_cfg_reg;
  logic [7:0]              layer_mix_cfg_reg;
  lcm_pkg::lcm_pstate_e    pstate_reg;
  lcm_pkg::lcm_disp_s      disp_reg;
  logic [15:0]             cursor_addr_reg;
  logic [15:0]             cursor_addr_next;
  logic [7:0]              rdata_next;
  logic                    layer1_text;
  logic                    use_l3;
  logic                    mixed;
  logic                    cur_hit;
  logic [8:0]              half_lines;
  logic [7:0]              panel_size;

  // parameter sequencing after form and overlay commands
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pstate_reg <= lcm_pkg::LCM_PS_IDLE;
    end else if (cmd_wr_in) begin
      case (cmd_data_in)
        `LCM_CMD_FORM:    pstate_reg <= lcm_pkg::LCM_PS_FORM0;
        `LCM_CMD_OVERLAY: pstate_reg <= lcm_pkg::LCM_PS_OVL0;
        default:          pstate_reg <= lcm_pkg::LCM_PS_IDLE;
      endcase
    end else if (prm_wr_in) begin
      case (pstate_reg)
        lcm_pkg::LCM_PS_FORM0: pstate_reg <= lcm_pkg::LCM_PS_FORM1;
        default:               pstate_reg <= lcm_pkg::LCM_PS_IDLE;
      endcase
    end
  end

  // cursor form registers: direct writes or form parameters
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cursor_width_cfg_reg        <= `LCM_RST_CURSOR_WIDTH;
      cursor_style_height_cfg_reg <= `LCM_RST_CURSOR_STYLE;
    end else if (reg_wr_in && reg_addr_in == `LCM_ADDR_CURSOR_WIDTH) begin
      cursor_width_cfg_reg <= reg_wdata_in & `LCM_WIDTH_MASK;
    end else if (reg_wr_in && reg_addr_in == `LCM_ADDR_CURSOR_STYLE) begin
      cursor_style_height_cfg_reg <= reg_wdata_in & `LCM_STYLE_MASK;
    end else if (prm_wr_in && pstate_reg == lcm_pkg::LCM_PS_FORM0) begin
      cursor_width_cfg_reg <= cmd_data_in & `LCM_WIDTH_MASK;
    end else if (prm_wr_in && pstate_reg == lcm_pkg::LCM_PS_FORM1) begin
      cursor_style_height_cfg_reg <= cmd_data_in & `LCM_STYLE_MASK;
    end
  end

  // step direction: direct write or one of the four single-byte commands
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cursor_step_direction_cfg_reg <= `LCM_RST_CURSOR_STEP;
    end else if (reg_wr_in && reg_addr_in == `LCM_ADDR_CURSOR_STEP) begin
      cursor_step_direction_cfg_reg <= reg_wdata_in & `LCM_STEP_MASK;
    end else if (cmd_wr_in && cmd_data_in >= `LCM_CMD_STEP_RIGHT
                 && cmd_data_in <= `LCM_CMD_STEP_DOWN) begin
      cursor_step_direction_cfg_reg <= {6'h00, cmd_data_in[1:0]};
    end
  end

  // overlay register: direct write or overlay parameter
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      layer_mix_cfg_reg <= `LCM_RST_LAYER_MIX;
    end else if (reg_wr_in && reg_addr_in == `LCM_ADDR_LAYER_MIX) begin
      layer_mix_cfg_reg <= reg_wdata_in & `LCM_MIX_MASK;
    end else if (prm_wr_in && pstate_reg == lcm_pkg::LCM_PS_OVL0) begin
      layer_mix_cfg_reg <= cmd_data_in & `LCM_MIX_MASK;
    end
  end

  // read mux; unmapped addresses answer zero
  always_comb begin
    case (reg_addr_in)
      `LCM_ADDR_CURSOR_WIDTH: rdata_next = cursor_width_cfg_reg;
      `LCM_ADDR_CURSOR_STYLE: rdata_next = cursor_style_height_cfg_reg;
      `LCM_ADDR_CURSOR_STEP:  rdata_next = cursor_step_direction_cfg_reg;
      `LCM_ADDR_LAYER_MIX:    rdata_next = layer_mix_cfg_reg;
      default:                rdata_next = 8'h00;
    endcase
  end

  // read data held until the next read strobe
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      reg_rdata_out <= rdata_next;
    end
  end

  // ========================================================================
  // cursor address stepping; plain address units, so nine-pixel cells
  // need software to preset the address itself
  always_comb begin
    case (lcm_pkg::lcm_dir_e'(cursor_step_direction_cfg_reg[1:0]))
      lcm_pkg::LCM_DIR_RIGHT: cursor_addr_next = cursor_addr_reg + 16'h0001;
      lcm_pkg::LCM_DIR_LEFT:  cursor_addr_next = cursor_addr_reg - 16'h0001;
      lcm_pkg::LCM_DIR_UP:    cursor_addr_next = cursor_addr_reg - addr_pitch_in;
      lcm_pkg::LCM_DIR_DOWN:  cursor_addr_next = cursor_addr_reg + addr_pitch_in;
      default:                cursor_addr_next = cursor_addr_reg;
    endcase
  end

  // load beats a simultaneous access so the new address is not skipped
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cursor_addr_reg <= 16'h0000;
    end else if (cursor_load_in) begin
      cursor_addr_reg <= cursor_load_val_in;
    end else if (mem_access_in) begin
      cursor_addr_reg <= cursor_addr_next;
    end
  end

  assign cursor_addr_out = cursor_addr_reg;

  // ========================================================================
  // settings latched at frame start so a frame never mixes old and new
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      disp_reg <= '0;
    end else if (frame_start_in) begin
      disp_reg.width       <= cursor_width_cfg_reg[3:0];
      disp_reg.height      <= cursor_style_height_cfg_reg[3:0];
      disp_reg.block_style <= cursor_style_height_cfg_reg[`LCM_STYLE_BIT];
      disp_reg.three_layer <= layer_mix_cfg_reg[`LCM_COUNT_BIT];
      disp_reg.b3_graphics <= layer_mix_cfg_reg[`LCM_B3TYPE_BIT];
      disp_reg.b1_graphics <= layer_mix_cfg_reg[`LCM_B1TYPE_BIT];
      disp_reg.mix         <= lcm_pkg::lcm_mix_e'(layer_mix_cfg_reg[1:0]);
    end
  end

  // ========================================================================
  // block heights: sizes are line counts minus one throughout
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      block_three_lines_out <= 8'h00;
      block_four_lines_out  <= 8'h00;
    end else begin
      block_three_lines_out <= (block_one_lines_in < block_two_lines_in) ?
                               block_one_lines_in : block_two_lines_in;
      block_four_lines_out  <= frame_lines_in;
    end
  end

  // dual panel: lines past a block's size up to the half height go blank
  assign half_lines = ({1'b0, frame_lines_in} + 9'h001) >> 1;
  assign panel_size = lower_panel_in ? block_two_lines_in : block_one_lines_in;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      blank_out <= 1'b0;
    end else begin
      blank_out <= dual_panel_in && (panel_line_in > panel_size)
                   && ({1'b0, panel_line_in} < half_lines);
    end
  end

  // ========================================================================
  // cursor shape; width/height beyond the cell is software's concern
  always_comb begin
    if (disp_reg.block_style) begin
      cur_hit = (cell_x_in <= disp_reg.width)
                && (cell_y_in <= disp_reg.height);
    end else begin
      cur_hit = (cell_x_in <= disp_reg.width)
                && (cell_y_in == disp_reg.height);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cursor_on_out <= 1'b0;
    end else begin
      cursor_on_out <= cursor_cell_in && cur_hit;
    end
  end

  // ========================================================================
  // layer composition; blocks two and four only ever feed graphics layers
  assign layer1_text = in_block_three_in ? !disp_reg.b3_graphics
                                         : !disp_reg.b1_graphics;
  assign use_l3      = disp_reg.three_layer && !layer1_text;

  // one method for the whole layer, whichever block supplies it
  always_comb begin
    case (disp_reg.mix)
      lcm_pkg::LCM_MIX_OR:  mixed = layers_in.l1 | layers_in.l2;
      lcm_pkg::LCM_MIX_XOR: mixed = layers_in.l1 ^ layers_in.l2;
      lcm_pkg::LCM_MIX_AND: mixed = layers_in.l1 & layers_in.l2;
      default:              mixed = layers_in.l1 | layers_in.l2;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pixel_out <= 1'b0;
    end else begin
      pixel_out <= mixed | (use_l3 & layers_in.l3);
    end
  end

  // ========================================================================
  // checks
  // display checks skip the frame pulse edge, where latched settings change
  a_step_right: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    mem_access_in && !cursor_load_in && cursor_step_direction_cfg_reg[1:0] == 2'b00
    |=> cursor_addr_reg == $past(cursor_addr_reg) + 16'h0001)
    else $error("cursor did not step right by one");

  a_step_down: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    mem_access_in && !cursor_load_in && cursor_step_direction_cfg_reg[1:0] == 2'b11
    |=> cursor_addr_reg == $past(cursor_addr_reg) + $past(addr_pitch_in))
    else $error("cursor did not step down by pitch");

  a_addr_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !mem_access_in && !cursor_load_in |=> $stable(cursor_addr_out))
    else $error("cursor address moved without access");

  a_step_cmd: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    cmd_wr_in && !reg_wr_in && cmd_data_in == 8'h4E |=> cursor_step_direction_cfg_reg == 8'h02)
    else $error("up command did not select up");

  a_form_seq: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    prm_wr_in && !reg_wr_in && pstate_reg == lcm_pkg::LCM_PS_FORM0
    |=> cursor_width_cfg_reg == ($past(cmd_data_in) & `LCM_WIDTH_MASK))
    else $error("form parameter not stored as width");

  a_frame_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !frame_start_in |=> $stable(disp_reg))
    else $error("display settings changed mid frame");

  a_b3_min: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ##1 block_three_lines_out <= $past(block_one_lines_in)
    && block_three_lines_out <= $past(block_two_lines_in))
    else $error("block three height exceeds a block size");

  a_no_l3_text: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    layer1_text && !layers_in.l1 && !layers_in.l2 && !frame_start_in |=> !pixel_out)
    else $error("third layer shown over text layer");

  a_xor_mix: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    disp_reg.mix == lcm_pkg::LCM_MIX_XOR && !use_l3 && !frame_start_in
    |=> pixel_out == ($past(layers_in.l1) ^ $past(layers_in.l2)))
    else $error("xor composition wrong");

  a_blank_off: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !dual_panel_in |=> !blank_out)
    else $error("blanking outside dual panel");

  a_blank_on: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    dual_panel_in && panel_line_in > panel_size
    && {panel_line_in, 1'b0} < {1'b0, frame_lines_in} |=> blank_out)
    else $error("line past block size not blanked");

  a_blank_size: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    panel_line_in <= panel_size |=> !blank_out)
    else $error("line inside block size blanked");

  a_b4_frame: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    ##1 block_four_lines_out == $past(frame_lines_in))
    else $error("block four size not lines per frame");

  a_rsv_or: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    disp_reg.mix == lcm_pkg::LCM_MIX_RSV && !use_l3 && !frame_start_in
    |=> pixel_out == ($past(layers_in.l1) | $past(layers_in.l2)))
    else $error("reserved mix not composed as or");

  a_block_cur: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    disp_reg.block_style && cursor_cell_in && !frame_start_in
    && cell_x_in <= disp_reg.width && cell_y_in <= disp_reg.height |=> cursor_on_out)
    else $error("block cursor pixel missing");

  a_under_line: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    !disp_reg.block_style && cell_y_in != disp_reg.height && !frame_start_in |=> !cursor_on_out)
    else $error("underscore cursor off its line");

  a_l3_pass: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
    disp_reg.three_layer && disp_reg.b1_graphics && !in_block_three_in && layers_in.l3
    && !frame_start_in |=> pixel_out)
    else $error("third layer pixel lost");

  // main scenarios reached
  c_step_cmd:  cover property (@(posedge core_clk_in) cmd_wr_in && cmd_data_in == 8'h4D);
  c_three_mix: cover property (@(posedge core_clk_in) use_l3 && layers_in.l3);
  c_blank:     cover property (@(posedge core_clk_in) blank_out);
  c_block_cur: cover property (@(posedge core_clk_in) cursor_on_out && disp_reg.block_style);
  c_form_prm:  cover property (@(posedge core_clk_in) prm_wr_in && pstate_reg == lcm_pkg::LCM_PS_FORM1);

endmodule // lcm_mixer

`default_nettype wire

// File: lcm_host_model.sv
// lcm_host_model.sv: host cpu that programs the mixer registers and commands
// assumes one clock shared with the mixer; requests launch after a rising edge
`timescale 1ns/1ps
`default_nettype none

module lcm_host_model (
  input  wire logic        core_clk_in,
  input  wire logic [7:0]  rdata_in,
  output var  logic        wr_out,
  output var  logic        rd_out,
  output var  logic        cmd_out,
  output var  logic        prm_out,
  output var  logic [15:0] addr_out,
  output var  logic [7:0]  data_out
);
  // ========================================================================
  // idle bus at time zero
  initial begin
    {wr_out, rd_out, cmd_out, prm_out} = 4'h0;
    addr_out = 16'h0000;
    data_out = 8'h00;
  end

  // kind 0 write, 1 read, 2 command, 3 parameter; one cycle strobe each
  task automatic xfer(input int kind, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    addr_out <= a;
    data_out <= d;
    {wr_out, rd_out, cmd_out, prm_out} <= 4'h8 >> kind;
    @(posedge core_clk_in);
    {wr_out, rd_out, cmd_out, prm_out} <= 4'h0;
    addr_out <= ~a; // released lines show no stale value
    data_out <= ~d;
  endtask

  // read data is registered, so it is taken once the strobe edge settles
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    xfer(1, a, 8'h00);
    #1;
    d = rdata_in;
  endtask
endmodule // lcm_host_model

`default_nettype wire

// File: lcm_mixer_tb.sv
// lcm_mixer_tb.sv: self-checking bench for the cursor and layer mixer
// assumes lcm_host_model drives the register and command ports
`timescale 1ns/1ps
`include "lcm_consts.svh"
`default_nettype none

module lcm_mixer_tb;
  logic                 clk, rst_n, wr, rd, cmd, prm, dp, ld, ma, fs, lo, ib3, cc;
  logic                 blank, con, pix;
  logic [7:0]           data, rdata, b1l, b2l, fl, pl, b3o, b4o;
  logic [15:0]          addr, pitch, ldv, cur;
  logic [3:0]           cx, cy;
  lcm_pkg::lcm_layers_s lay;
  int                   n_fail, samples_checked, cyc;

  lcm_mixer lcm_mixer_inst (.core_clk_in(clk), .rst_n_in(rst_n), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(data), .reg_rdata_out(rdata),
    .cmd_wr_in(cmd), .prm_wr_in(prm), .cmd_data_in(data), .block_one_lines_in(b1l),
    .block_two_lines_in(b2l), .frame_lines_in(fl), .addr_pitch_in(pitch),
    .dual_panel_in(dp), .cursor_load_in(ld), .cursor_load_val_in(ldv),
    .mem_access_in(ma), .cursor_addr_out(cur), .frame_start_in(fs),
    .panel_line_in(pl), .lower_panel_in(lo), .in_block_three_in(ib3),
    .cursor_cell_in(cc), .cell_x_in(cx), .cell_y_in(cy), .layers_in(lay),
    .block_three_lines_out(b3o), .block_four_lines_out(b4o), .blank_out(blank),
    .cursor_on_out(con), .pixel_out(pix));

  lcm_host_model lcm_host_model_inst (.core_clk_in(clk), .rdata_in(rdata), .wr_out(wr),
    .rd_out(rd), .cmd_out(cmd), .prm_out(prm), .addr_out(addr), .data_out(data));

  // ========================================================================
  // shared helpers
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    lcm_host_model_inst.xfer(0, a, d);
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    lcm_host_model_inst.rd(a, d);
    chk(16'(d), 16'(e));
  endtask

  // settings only move into the display path on a frame pulse
  task automatic frame;
    @(posedge clk) fs <= 1'b1;
    @(posedge clk) fs <= 1'b0;
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ========================================================================
  // scenarios
  task automatic t_regs;
    logic [7:0] m [4];
    m = '{`LCM_WIDTH_MASK, `LCM_STYLE_MASK, `LCM_STEP_MASK, `LCM_MIX_MASK};
    for (int i = 0; i < 4; i++) begin
      rd_chk(`LCM_ADDR_CURSOR_WIDTH + 16'(i), 8'h00);
      wr_reg(`LCM_ADDR_CURSOR_WIDTH + 16'(i), 8'hFF);
      rd_chk(`LCM_ADDR_CURSOR_WIDTH + 16'(i), m[i]);
    end
    wr_reg(16'h8019, 8'hAA); // unmapped write must be dropped
    rd_chk(16'h8019, 8'h00);
    rd_chk(16'h8014, 8'h00);
    $display("done regs");
  endtask

  task automatic t_ind;
    lcm_host_model_inst.xfer(2, 16'h0000, `LCM_CMD_FORM);
    lcm_host_model_inst.xfer(3, 16'h0000, 8'h05);
    lcm_host_model_inst.xfer(3, 16'h0000, 8'h83);
    lcm_host_model_inst.xfer(3, 16'h0000, 8'h0A); // surplus byte
    rd_chk(`LCM_ADDR_CURSOR_WIDTH, 8'h05);
    rd_chk(`LCM_ADDR_CURSOR_STYLE, 8'h83);
    lcm_host_model_inst.xfer(2, 16'h0000, `LCM_CMD_OVERLAY);
    lcm_host_model_inst.xfer(3, 16'h0000, 8'h1D);
    rd_chk(`LCM_ADDR_LAYER_MIX, 8'h1D);
    for (int i = 0; i < 4; i++) begin
      lcm_host_model_inst.xfer(2, 16'h0000, `LCM_CMD_STEP_RIGHT + 8'(i));
      rd_chk(`LCM_ADDR_CURSOR_STEP, 8'(i));
    end
    $display("done indirect");
  endtask

  task automatic t_step;
    logic [15:0] e;
    e = 16'h1000;
    @(posedge clk) {ld, ldv, pitch} <= {1'b1, 16'h1000, 16'h0020};
    @(posedge clk) ld <= 1'b0;
    for (int d = 0; d < 4; d++) begin
      wr_reg(`LCM_ADDR_CURSOR_STEP, 8'(d));
      @(posedge clk) ma <= 1'b1;
      @(posedge clk) ma <= 1'b0;
      #1;
      e = (d < 2) ? e + (d == 1 ? 16'hFFFF : 16'h0001) : e + (d == 3 ? 16'h0020 : 16'hFFE0);
      chk(cur, e);
    end
    @(posedge clk) {ld, ma, ldv} <= {2'b11, 16'h2345}; // load beats a step
    @(posedge clk) {ld, ma} <= 2'b00;
    #1;
    chk(cur, 16'h2345);
    $display("done step");
  endtask

  // block sizes are line counts minus one
  task automatic blk(input logic [7:0] b1, b2, f, p, input logic d, l);
    logic [8:0] half;
    half = ({1'b0, f} + 9'h001) >> 1;
    @(posedge clk) {b1l, b2l, fl, pl, dp, lo} <= {b1, b2, f, p, d, l};
    @(posedge clk) #1;
    chk(16'(blank), 16'(d & (p > (l ? b2 : b1)) & ({1'b0, p} < half)));
    chk(16'(b3o), 16'(b1 < b2 ? b1 : b2));
    chk(16'(b4o), 16'(f));
  endtask

  task automatic t_blank;
    blk(8'h0A, 8'h14, 8'h3F, 8'h0F, 1'b1, 1'b0);
    blk(8'h0A, 8'h14, 8'h3F, 8'h0A, 1'b1, 1'b0);
    blk(8'h0A, 8'h14, 8'h3F, 8'h0F, 1'b1, 1'b1);
    blk(8'h0A, 8'h14, 8'h3F, 8'h19, 1'b1, 1'b1);
    blk(8'h14, 8'h0A, 8'h3F, 8'h20, 1'b1, 1'b0);
    blk(8'h14, 8'h0A, 8'h3F, 8'h1F, 1'b0, 1'b0);
    $display("done blank");
  endtask

  task automatic t_cursor;
    logic e;
    for (int s = 0; s < 2; s++) begin
      wr_reg(`LCM_ADDR_CURSOR_STYLE, 8'(s << 7) | 8'h02);
      wr_reg(`LCM_ADDR_CURSOR_WIDTH, 8'h03);
      frame();
      for (int k = 0; k < 256; k++) begin
        @(posedge clk) {cc, cx, cy} <= {1'b1, 4'(k), 4'(k >> 4)};
        @(posedge clk) #1;
        e = (4'(k) <= 4'h3) && (s == 1 ? 4'(k >> 4) <= 4'h2 : 4'(k >> 4) == 4'h2);
        chk(16'(con), 16'(e));
      end
    end
    wr_reg(`LCM_ADDR_CURSOR_WIDTH, 8'h00); // no frame pulse yet
    @(posedge clk) {cx, cy} <= {4'h3, 4'h1};
    @(posedge clk) cc <= 1'b0;
    #1;
    chk(16'(con), 16'h0001);
    @(posedge clk) #1;
    chk(16'(con), 16'h0000);
    $display("done cursor");
  endtask

  task automatic t_mix;
    logic [2:0] l;
    logic       u;
    logic       e;
    for (int v = 0; v < 32; v++) begin
      wr_reg(`LCM_ADDR_LAYER_MIX, 8'(v));
      frame();
      for (int k = 0; k < 16; k++) begin
        l = 3'(k);
        @(posedge clk) {lay, ib3} <= {l, k[3]};
        @(posedge clk) #1;
        u = v[4] & (k[3] ? v[3] : v[2]);
        e = (v[1:0] == 2'b01) ? l[2] ^ l[1] : (v[1:0] == 2'b10) ? l[2] & l[1] : l[2] | l[1];
        chk(16'(pix), 16'(e | (l[0] & u)));
      end
    end
    $display("done mix");
  endtask

  // ========================================================================
  // clock, hang guard and main sequence
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    {rst_n, dp, ld, ma, fs, lo, ib3, cc, cx, cy} = '0;
    {b1l, b2l, fl, pl, pitch, ldv, lay} = '0;
    {n_fail, samples_checked, cyc} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_ind();
    t_step();
    t_blank();
    t_cursor();
    t_mix();
    close_out();
  end
endmodule // lcm_mixer_tb

`default_nettype wire
